// ==== hw/wkp_params.svh ====
`ifndef WKP_PARAMS_SVH
`define WKP_PARAMS_SVH

// Register byte addresses.
`define WKP_ADDR_CFG 8'h00
`define WKP_ADDR_FLAG 8'h04
`define WKP_ADDR_MASK 8'h08
`define WKP_ADDR_STATE 8'h0c
`define WKP_ADDR_W 8

// Configuration register field positions.
`define WKP_CFG_FILT_LSB 0
`define WKP_CFG_LVL_LSB 2
`define WKP_CFG_HID_LSB 6
`define WKP_CFG_ANALOG_MUX_OUTPUT_LSB 8
`define WKP_CFG_RESET 32'h0000_0000
`define WKP_MASK_RESET 2'h0

// Status register field positions.
`define WKP_ST_FILT_LSB 0
`define WKP_ST_WAKE_LSB 2
`define WKP_ST_HID_LSB 4
`define WKP_ST_LP_BIT 6

// Wake level select codes.
`define WKP_LVL_HIGH 2'h1
`define WKP_LVL_LOW 2'h2

// Pull configuration codes.
`define WKP_PULL_OFF 2'h0
`define WKP_PULL_DOWN 2'h1
`define WKP_PULL_UP 2'h2
`define WKP_PULL_REPEAT 2'h3

// Bus answers.
`define WKP_RESP_OKAY 2'h0
`define WKP_RESP_SLVERR 2'h2

// Filter times and clock period.
`define WKP_CLK_PERIOD_NS 40
`define WKP_FLT_SHORT_NS 15000
`define WKP_FLT_LONG_NS 65000
`define WKP_FLT_SHORT_CYC \
    ((`WKP_FLT_SHORT_NS + `WKP_CLK_PERIOD_NS - 1) / `WKP_CLK_PERIOD_NS)
`define WKP_FLT_LONG_CYC \
    ((`WKP_FLT_LONG_NS + `WKP_CLK_PERIOD_NS - 1) / `WKP_CLK_PERIOD_NS)
`define WKP_CNT_W 11

`endif

// ==== hw/wkp_pkg.sv ====
`include "wkp_params.svh"

package wkp_pkg;

    // Bus request from the master, grouped by channel.
    typedef struct packed {
        logic awvalid;
        logic [`WKP_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`WKP_ADDR_W-1:0] araddr;
        logic rready;
    } wkp_axi_req_s;

    // Bus answer from the slave.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wkp_axi_rsp_s;

    // Whole state of the block.
    typedef struct packed {
        logic [1:0][2:0] sync;
        logic [1:0][`WKP_CNT_W-1:0] cnt;
        logic [1:0] filt;
        logic [1:0] flag;
        logic [1:0] mask;
        logic [31:0] cfg;
        logic [1:0] wake_req;
        logic [1:0] hid_act;
        logic [1:0] pull_up;
        logic [1:0] pull_dn;
        logic [1:0] analog_mux_output_sel;
        logic irq;
        logic aw_have;
        logic w_have;
        logic [`WKP_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        wkp_axi_rsp_s rsp;
    } wkp_state_s;

endpackage

// ==== hw/wkp_wake_pins.sv ====
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "wkp_params.svh"

module wkp_wake_pins
    import wkp_pkg::*;
#(
    parameter int FLT_SHORT_CYC = `WKP_FLT_SHORT_CYC,
    parameter int FLT_LONG_CYC = `WKP_FLT_LONG_CYC
) (
    input wire logic CLK_SYS_IN, // System clock, 25 MHz.
    input wire logic RESET_IN, // Synchronous reset, active high.
    input wire wkp_axi_req_s AXI_REQ_IN, // Register bus request.
    output wkp_axi_rsp_s AXI_RSP_OUT, // Register bus answer.
    input wire logic [1:0] WAKE_PIN_IN, // Pin a bit 0, pin b bit 1.
    input wire logic LOW_POWER_IN, // Device is in a low-power mode.
    input wire logic [3:0] WAKE_PULL_CONFIG_IN, // Fused pull codes.
    output logic [1:0] WAKE_REQ_OUT, // Wake-up request per pin.
    output logic [1:0] HW_IDENT_ACTIVE_OUT, // Pin in ident role.
    output logic [1:0] PULLUP_EN_OUT, // Pullup resistor enable.
    output logic [1:0] PULLDN_EN_OUT, // Pulldown resistor enable.
    output logic [1:0] ANALOG_MUX_SEL_OUT, // Pin routed to mux.
    output logic IRQ_OUT // Interrupt, active high level.
);

    // Refuse filter lengths the counters cannot reach.
    if (FLT_SHORT_CYC < 1 || FLT_LONG_CYC < FLT_SHORT_CYC ||
        FLT_LONG_CYC >= (1 << `WKP_CNT_W)) begin : g_chk
        $error("Filter cycle counts out of range.");
    end

    localparam logic [`WKP_CNT_W-1:0] LIM_S = FLT_SHORT_CYC[`WKP_CNT_W-1:0];
    localparam logic [`WKP_CNT_W-1:0] LIM_L = FLT_LONG_CYC[`WKP_CNT_W-1:0];

    wkp_state_s st_reg;
    wkp_state_s st_next;
    logic [1:0] ev;
    logic [1:0] clr;

    // Expand byte strobes into a bit mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    // Pull decode shared by every pin.
    function automatic logic [1:0] pull_of(input logic [1:0] code,
                                           input logic lvl);
        unique case (code)
            `WKP_PULL_OFF: pull_of = 2'h0;
            `WKP_PULL_DOWN: pull_of = 2'h1;
            `WKP_PULL_UP: pull_of = 2'h2;
            `WKP_PULL_REPEAT: pull_of = lvl ? 2'h2 : 2'h1;
        endcase
    endfunction

    // All next-state logic of the block.
    always_comb begin
        logic [`WKP_CNT_W-1:0] lim;
        logic [1:0] lvl;
        logic [1:0] pl;
        logic [31:0] wm;
        logic [31:0] rd;
        lim = LIM_S;
        lvl = 2'h0;
        pl = 2'h0;
        wm = 32'h0000_0000;
        rd = 32'h0000_0000;
        st_next = st_reg;
        ev = 2'h0;
        clr = 2'h0;
        for (int i = 0; i < 2; i++) begin
            // Three-stage sampling; the first stage feeds only the second.
            st_next.sync[i] = {st_reg.sync[i][1:0], WAKE_PIN_IN[i]};
            lim = st_reg.cfg[`WKP_CFG_FILT_LSB + i] ? LIM_L : LIM_S;
            // The filtered level moves only after a stable run.
            if (st_reg.sync[i][1] == st_reg.sync[i][2] &&
                st_reg.sync[i][2] != st_reg.filt[i]) begin
                if (st_reg.cnt[i] >= lim - 11'h001) begin
                    st_next.filt[i] = st_reg.sync[i][2];
                    st_next.cnt[i] = '0;
                end else begin
                    st_next.cnt[i] = st_reg.cnt[i] + 11'h001;
                end
            end else begin
                st_next.cnt[i] = '0;
            end
            ev[i] = st_next.filt[i] ^ st_reg.filt[i];
            // Ident role only in normal mode when enabled.
            st_next.hid_act[i] = st_reg.cfg[`WKP_CFG_HID_LSB + i] &
                                 ~LOW_POWER_IN;
            lvl = st_reg.cfg[`WKP_CFG_LVL_LSB + 2*i +: 2];
            // Level-triggered wake request in low-power modes.
            st_next.wake_req[i] = LOW_POWER_IN &
                ((lvl == `WKP_LVL_HIGH && st_reg.filt[i]) ||
                 (lvl == `WKP_LVL_LOW && !st_reg.filt[i]));
            pl = pull_of(WAKE_PULL_CONFIG_IN[2*i +: 2],
                         st_reg.filt[i]);
            st_next.pull_up[i] = pl[1];
            st_next.pull_dn[i] = pl[0];
            st_next.analog_mux_output_sel[i] = st_reg.cfg[`WKP_CFG_ANALOG_MUX_OUTPUT_LSB + i];
        end

        // Write channel: address and data accepted in either order.
        if (AXI_REQ_IN.awvalid && st_reg.rsp.awready) begin
            st_next.aw_have = 1'b1;
            st_next.awaddr = AXI_REQ_IN.awaddr;
        end
        if (AXI_REQ_IN.wvalid && st_reg.rsp.wready) begin
            st_next.w_have = 1'b1;
            st_next.wdata = AXI_REQ_IN.wdata;
            st_next.wstrb = AXI_REQ_IN.wstrb;
        end
        if (st_reg.rsp.bvalid && AXI_REQ_IN.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.rsp.bvalid) begin
            wm = lane_mask(st_reg.wstrb);
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = `WKP_RESP_OKAY;
            unique case (st_reg.awaddr)
                `WKP_ADDR_CFG:
                    st_next.cfg = (st_reg.cfg & ~wm) | (st_reg.wdata & wm);
                `WKP_ADDR_FLAG: clr = st_reg.wdata[1:0] & wm[1:0];
                `WKP_ADDR_MASK: begin
                    st_next.mask = (st_reg.mask & ~wm[1:0]) |
                                   (st_reg.wdata[1:0] & wm[1:0]);
                end
                `WKP_ADDR_STATE: ;
                default: st_next.rsp.bresp = `WKP_RESP_SLVERR;
            endcase
        end
        st_next.cfg[31:10] = '0;
        st_next.rsp.awready = !st_next.aw_have && !st_next.rsp.bvalid;
        st_next.rsp.wready = !st_next.w_have && !st_next.rsp.bvalid;

        // Flags: a new event wins over a clear in the same cycle.
        st_next.flag = (st_reg.flag & ~clr) |
                       (ev & ~st_reg.mask & ~st_next.hid_act &
                        {2{~LOW_POWER_IN}});
        st_next.irq = |(st_next.flag & ~st_next.mask);

        // Read channel: one read in flight, answered the next cycle.
        if (st_reg.rsp.rvalid && AXI_REQ_IN.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end
        if (AXI_REQ_IN.arvalid && st_reg.rsp.arready) begin
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rresp = `WKP_RESP_OKAY;
            unique case (AXI_REQ_IN.araddr)
                `WKP_ADDR_CFG: rd = st_reg.cfg;
                `WKP_ADDR_FLAG: rd = {30'h0, st_reg.flag};
                `WKP_ADDR_MASK: rd = {30'h0, st_reg.mask};
                `WKP_ADDR_STATE: begin
                    rd[`WKP_ST_FILT_LSB +: 2] = st_reg.filt;
                    rd[`WKP_ST_WAKE_LSB +: 2] = st_reg.wake_req;
                    rd[`WKP_ST_HID_LSB +: 2] = st_reg.hid_act;
                    rd[`WKP_ST_LP_BIT] = LOW_POWER_IN;
                end
                default: st_next.rsp.rresp = `WKP_RESP_SLVERR;
            endcase
            st_next.rsp.rdata = rd;
        end
        st_next.rsp.arready = !st_next.rsp.rvalid;
    end

    // Single register bank; reset clears everything to a known state.
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output is a flip-flop of the state.
    assign AXI_RSP_OUT = st_reg.rsp;
    assign WAKE_REQ_OUT = st_reg.wake_req;
    assign HW_IDENT_ACTIVE_OUT = st_reg.hid_act;
    assign PULLUP_EN_OUT = st_reg.pull_up;
    assign PULLDN_EN_OUT = st_reg.pull_dn;
    assign ANALOG_MUX_SEL_OUT = st_reg.analog_mux_output_sel;
    assign IRQ_OUT = st_reg.irq;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);

    // An unmasked normal-mode event on pin a shows as a flag.
    property p_flag_set;
        ev[0] && !LOW_POWER_IN && !st_reg.mask[0] && !st_next.hid_act[0]
            |=> st_reg.flag[0] ##1 IRQ_OUT;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("Unmasked wake event did not raise flag.");

    // A masked event never sets a clear flag.
    property p_flag_masked;
        ev[1] && st_reg.mask[1] && !st_reg.flag[1] |=> !st_reg.flag[1];
    endproperty
    a_flag_masked: assert property (p_flag_masked)
        else $error("Masked wake event set a flag.");

    // A set flag holds unless a one is written to it.
    property p_flag_sticky;
        st_reg.flag[0] && !clr[0] |=> st_reg.flag[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("Wake flag dropped without a clear.");

    // High-level wake setting gives a request one cycle on.
    property p_wake_high;
        LOW_POWER_IN && st_reg.cfg[3:2] == `WKP_LVL_HIGH && st_reg.filt[0]
            |=> WAKE_REQ_OUT[0];
    endproperty
    a_wake_high: assert property (p_wake_high)
        else $error("High-level wake request missing.");

    // The filtered level changes only after a full stable run.
    property p_filt_len;
        $changed(st_reg.filt[0]) |->
            $past(st_reg.cnt[0]) ==
            ($past(st_reg.cfg[0]) ? LIM_L : LIM_S) - 11'h001;
    endproperty
    a_filt_len: assert property (p_filt_len)
        else $error("Filter passed a level too early.");

    // The filter select bit picks the long run.
    property p_filt_sel;
        st_reg.cfg[1] && st_reg.cnt[1] != 11'h000 |-> st_reg.cnt[1] < LIM_L;
    endproperty
    a_filt_sel: assert property (p_filt_sel)
        else $error("Filter count past the long limit.");

    // Repeater mode drives the pull that matches the level.
    property p_repeat;
        WAKE_PULL_CONFIG_IN[1:0] == `WKP_PULL_REPEAT
            |=> PULLUP_EN_OUT[0] == $past(st_reg.filt[0]) &&
                PULLDN_EN_OUT[0] == !$past(st_reg.filt[0]);
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("Repeater pull does not follow level.");

    // Disabled pulls stay off.
    property p_pull_off;
        WAKE_PULL_CONFIG_IN[3:2] == `WKP_PULL_OFF
            |=> !PULLUP_EN_OUT[1] && !PULLDN_EN_OUT[1];
    endproperty
    a_pull_off: assert property (p_pull_off)
        else $error("Pull driven while disabled.");

    // Ident role appears only in normal mode with its enable.
    property p_ident;
        HW_IDENT_ACTIVE_OUT[0] |->
            !$past(LOW_POWER_IN) && $past(st_reg.cfg[6]);
    endproperty
    a_ident: assert property (p_ident)
        else $error("Ident role active outside normal mode.");

    // A pin in the ident role raises no wake flag.
    property p_ident_noflag;
        st_next.hid_act[1] && !st_reg.flag[1] |=> !st_reg.flag[1];
    endproperty
    a_ident_noflag: assert property (p_ident_noflag)
        else $error("Ident pin raised a wake flag.");

    // The analog route follows its setting.
    property p_analog_mux_output;
        st_reg.cfg[8] |=> ANALOG_MUX_SEL_OUT[0];
    endproperty
    a_analog_mux_output: assert property (p_analog_mux_output)
        else $error("Analog route not applied.");

    // Low-level wake setting on pin b gives a request one cycle on.
    property p_wake_low;
        LOW_POWER_IN && st_reg.cfg[5:4] == `WKP_LVL_LOW && !st_reg.filt[1]
            |=> WAKE_REQ_OUT[1];
    endproperty
    a_wake_low: assert property (p_wake_low)
        else $error("Low-level wake request missing.");

    // The interrupt line mirrors the unmasked flags at every edge.
    property p_irq_level;
        IRQ_OUT == |(st_reg.flag & ~st_reg.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt line does not match unmasked flags.");

    c_irq: cover property (IRQ_OUT ##1 !IRQ_OUT);
    c_wake: cover property (LOW_POWER_IN ##1 WAKE_REQ_OUT[1]);
    c_race: cover property (ev[0] && clr[0] && !st_reg.mask[0]);
    c_long: cover property (st_reg.cfg[0] && $changed(st_reg.filt[0]));

endmodule

`default_nettype wire

// ==== testbench/wake_input_pins_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

`include "wkp_params.svh"

module wake_input_pins_tb;
    import wkp_pkg::*;
    localparam int FS = 4;
    localparam int FL = 12;
    localparam int SL = FL + 10;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wkp_axi_req_s rq = '0;
    wkp_axi_rsp_s rsp;
    logic lp = 1'b0;
    logic [3:0] pcfg = 4'h0;
    logic [1:0] lvl = 2'b00;
    logic [1:0] drv = 2'b11;
    wire logic [1:0] pin;
    logic [1:0] wreq, hid, pu, pd, analog_mux_output;
    logic irq;
    logic [1:0] amx;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    logic [1:0] expb[$];
    logic [33:0] expr[$];

    // A 40 ns period; the filter counts are shortened to 4 and 12 cycles, not real time.
    always #20 clk = ~clk;

    wkp_wake_pins #(.FLT_SHORT_CYC(FS), .FLT_LONG_CYC(FL)) wkp_wake_pins_inst (
        .CLK_SYS_IN(clk), .RESET_IN(rst), .AXI_REQ_IN(rq), .AXI_RSP_OUT(rsp),
        .WAKE_PIN_IN(pin), .LOW_POWER_IN(lp), .WAKE_PULL_CONFIG_IN(pcfg),
        .WAKE_REQ_OUT(wreq), .HW_IDENT_ACTIVE_OUT(hid), .PULLUP_EN_OUT(pu),
        .PULLDN_EN_OUT(pd), .ANALOG_MUX_SEL_OUT(analog_mux_output), .IRQ_OUT(irq));

    // One line model per pin, fed back by the device's pull enables.
    for (genvar i = 0; i < 2; i++) begin : g_line
        wkp_wake_line wkp_wake_line_inst (.clk_in(clk), .drive_in(drv[i]),
            .level_in(lvl[i]), .pull_up_in(pu[i]), .pull_dn_in(pd[i]),
            .pin_out(pin[i]));
    end

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Address and data go out together; each drops once it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        expb.push_back(r);
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= d;
        rq.wstrb <= 4'hf;
        rq.bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (rq.awvalid && rsp.awready) begin
                aw = 1'b1;
                rq.awvalid <= 1'b0;
            end
            if (rq.wvalid && rsp.wready) begin
                w = 1'b1;
                rq.wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        rq.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        expr.push_back({r, d});
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        rq.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1) @(posedge clk);
        rq.rready <= 1'b0;
    endtask

    task automatic pulse(input int i, input int w);
        lvl[i] <= ~lvl[i];
        settle(w);
        lvl[i] <= ~lvl[i];
        settle(SL);
    endtask

    function automatic logic [31:0] st(logic [1:0] f, w, h);
        return {25'h0, lp, h, w, f};
    endfunction

    // Answers are checked in arrival order; a hang ends the run.
    always @(posedge clk) begin
        cyc++;
        if (rsp.bvalid && rq.bready && expb.size() > 0) begin
            chk(rsp.bresp, expb.pop_front());
        end
        if (rsp.rvalid && rq.rready && expr.size() > 0) begin
            chk({rsp.rresp, rsp.rdata}, expr.pop_front());
        end
        if (cyc >= LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    // Main sequence; each step leaves the pins at a known level.
    initial begin
        void'($urandom(32'h20ae));
        settle(20);
        rst <= 1'b0;
        settle(2);
        rd(`WKP_ADDR_CFG, 32'h0, `WKP_RESP_OKAY);
        rd(`WKP_ADDR_MASK, 32'h0, `WKP_RESP_OKAY);
        rd(`WKP_ADDR_STATE, st(2'b00, 2'b00, 2'b00), `WKP_RESP_OKAY);
        rd(8'h10, 32'h0, `WKP_RESP_SLVERR);
        wr(8'h10, 32'hffff_ffff, `WKP_RESP_SLVERR);
        lvl <= 2'b01;
        settle(SL);
        chk(irq, 1'b1);
        rd(`WKP_ADDR_FLAG, 32'h1, `WKP_RESP_OKAY);
        wr(`WKP_ADDR_MASK, 32'h1, `WKP_RESP_OKAY);
        settle(2);
        chk(irq, 1'b0);
        wr(`WKP_ADDR_FLAG, 32'h1, `WKP_RESP_OKAY);
        lvl <= 2'b00;
        settle(SL);
        rd(`WKP_ADDR_FLAG, 32'h0, `WKP_RESP_OKAY);
        wr(`WKP_ADDR_MASK, 32'h0, `WKP_RESP_OKAY);
        lvl <= 2'b10;
        settle(SL);
        wr(`WKP_ADDR_FLAG, 32'h1, `WKP_RESP_OKAY);
        settle(SL);
        rd(`WKP_ADDR_FLAG, 32'h2, `WKP_RESP_OKAY);
        wr(`WKP_ADDR_FLAG, 32'h2, `WKP_RESP_OKAY);
        settle(2);
        rd(`WKP_ADDR_FLAG, 32'h0, `WKP_RESP_OKAY);
        chk(irq, 1'b0);
        // Glitches shorter than the selected filter must leave no trace.
        pulse(0, 1 + int'($urandom % 2));
        rd(`WKP_ADDR_FLAG, 32'h0, `WKP_RESP_OKAY);
        wr(`WKP_ADDR_CFG, 32'h2, `WKP_RESP_OKAY);
        pulse(1, 8);
        rd(`WKP_ADDR_FLAG, 32'h0, `WKP_RESP_OKAY);
        pulse(1, 20);
        rd(`WKP_ADDR_FLAG, 32'h2, `WKP_RESP_OKAY);
        wr(`WKP_ADDR_FLAG, 32'h3, `WKP_RESP_OKAY);
        // Pin a wakes on high, pin b on low; no flags in low power.
        wr(`WKP_ADDR_CFG, 32'h25, `WKP_RESP_OKAY);
        lp <= 1'b1;
        lvl <= 2'b11;
        settle(SL);
        chk(wreq, 2'b01);
        lvl <= 2'b01;
        settle(SL);
        chk(wreq, 2'b11);
        rd(`WKP_ADDR_FLAG, 32'h0, `WKP_RESP_OKAY);
        rd(`WKP_ADDR_STATE, st(2'b01, 2'b11, 2'b00), `WKP_RESP_OKAY);
        lp <= 1'b0;
        settle(3);
        chk(wreq, 2'b00);
        amx = 2'($urandom) | 2'h1;
        wr(`WKP_ADDR_CFG, {22'h0, amx, 8'hc0}, `WKP_RESP_OKAY);
        settle(3);
        chk(hid, 2'b11);
        chk(analog_mux_output, amx);
        lvl <= 2'b10;
        settle(SL);
        rd(`WKP_ADDR_FLAG, 32'h0, `WKP_RESP_OKAY);
        rd(`WKP_ADDR_STATE, st(2'b10, 2'b00, 2'b11), `WKP_RESP_OKAY);
        lp <= 1'b1;
        settle(3);
        chk(hid, 2'b00);
        lp <= 1'b0;
        wr(`WKP_ADDR_CFG, 32'h0, `WKP_RESP_OKAY);
        // Every fused pull code; the repeater follows the filtered levels.
        for (int c = 0; c < 4; c++) begin
            pcfg <= {2'(c), 2'(c)};
            settle(3);
            chk({pu, pd}, c == 3 ? 4'h9 : {{2{c == 2}}, {2{c == 1}}});
        end
        drv <= 2'b00;
        settle(SL);
        chk({pu, pd}, 4'b1001);
        rd(`WKP_ADDR_STATE, st(2'b10, 2'b00, 2'b00), `WKP_RESP_OKAY);
        drv <= 2'b11;
        settle(5);
        wrap_up();
    end
endmodule

`default_nettype wire

// ==== testbench/wkp_wake_line.sv ====
`timescale 1ns/100ps
`default_nettype none

// Wake line seen from the device pin: a driven source or a pulled node.
module wkp_wake_line (
    input wire logic clk_in, // Bench clock, moves the line after an edge.
    input wire logic drive_in, // Source drives the line.
    input wire logic level_in, // Level driven by the source.
    input wire logic pull_up_in, // Device pullup enable.
    input wire logic pull_dn_in, // Device pulldown enable.
    output logic pin_out // Level at the pin.
);
    initial pin_out = 1'b0;

    // A released, unpulled line wanders, so it toggles rather than holds.
    always @(posedge clk_in) begin
        if (drive_in) begin
            pin_out <= level_in;
        end else if (pull_up_in) begin
            pin_out <= 1'b1;
        end else if (pull_dn_in) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= ~pin_out;
        end
    end
endmodule

`default_nettype wire
